// File: verilog/mlt_consts.svh
`ifndef MLT_CONSTS_SVH
`define MLT_CONSTS_SVH

// ----------------------------------------------------------
// Bit-cell phase points (sixteen phases per cell).
// ----------------------------------------------------------
`define MLT_PH_Q1 4'h4
`define MLT_PH_MID 4'h8
`define MLT_PH_Q3 4'hc
`define MLT_PH_LAST 4'hf
`define MLT_PH_SHORT 4'h1
`define MLT_PH_RELOCK 4'h9
`define MLT_PH_TXSAMP 4'h4

// ----------------------------------------------------------
// Early and late correction windows.
// ----------------------------------------------------------
`define MLT_WIN_E_LO 4'h5
`define MLT_WIN_E_HI 4'h7
`define MLT_WIN_L_LO 4'h9
`define MLT_WIN_L_HI 4'hb

// ----------------------------------------------------------
// Preamble, activity and acquisition counts.
// ----------------------------------------------------------
`define MLT_PRE_BITS 8'hab
`define MLT_PRE_LEN 4'h8
`define MLT_CTS_AT 4'h6
`define MLT_ACQ_WIN 5'h10
`define MLT_GAP_MAX 5'h1f
`define MLT_QUIET_LAST 6'h1f

// ----------------------------------------------------------
// Reset value of the pin synchroniser (request idle high).
// ----------------------------------------------------------
`define MLT_PIN_INIT 4'h2

`endif

// File: verilog/mlt_pkg.sv
package mlt_pkg;

  // ----------------------------------------------------------
  // Transmit sequencer states.
  // ----------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA} mltTx_e;

  // ----------------------------------------------------------
  // Pins that arrive from outside the clock domain.
  // ----------------------------------------------------------
  typedef struct packed {
    logic lineRx;
    logic txData;
    logic rtsN;
    logic modeSel;
  } mltPins_s;

  // ----------------------------------------------------------
  // State of the transceiver core, apart from the transmit divider, synchroniser and buffer.
  // ----------------------------------------------------------
  typedef struct packed {
    mltTx_e txState;
    logic [3:0] txCnt;
    logic txBit;
    logic lineOut;
    logic driveN;
    logic cts;
    logic [3:0] rxPh;
    logic rxPrev;
    logic locked;
    logic acq;
    logic active;
    logic [5:0] quiet;
    logic [4:0] gap;
    logic shorten;
    logic lengthen;
    logic s4;
    logic hunt;
    logic lastOne;
    logic pend;
    logic pendV;
    logic rxClk;
    logic rxData;
    logic carrier;
    logic actN;
  } mltState_s;

endpackage

// File: verilog/mlt_sync.sv
`include "mlt_consts.svh"

// Three-stage synchroniser; the output only follows once the
// second and third stages agree, so a runt pulse is dropped.
module mlt_sync
  import mlt_pkg::*;
#(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] ff1_q; // First stage, read only by the second.
  logic [W-1:0] ff2_q; // Second stage.
  logic [W-1:0] ff3_q; // Third stage.
  logic [W-1:0] out_q; // Agreed value.

  // ----------------------------------------------------------
  // Stages and agreement filter.
  // ----------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ff1_q <= INIT;
      ff2_q <= INIT;
      ff3_q <= INIT;
      out_q <= INIT;
    end else begin
      ff1_q <= din;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      // Each bit moves only where stages two and three agree.
      out_q <= (~(ff2_q ^ ff3_q) & ff3_q) | ((ff2_q ^ ff3_q) & out_q);
    end
  end

  assign dout = out_q;

endmodule // mlt_sync

// File: verilog/mlt_fifo.sv
`include "mlt_consts.svh"

// Small first-in first-out buffer with valid and ready on both
// sides. Depth must be a power of two so pointers wrap freely.
module mlt_fifo
  import mlt_pkg::*;
#(
  parameter int W = 1,
  parameter int D = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D]; // Storage words.
  logic [AW-1:0] wrPtr_q; // Next slot to fill.
  logic [AW-1:0] rdPtr_q; // Next slot to drain.
  logic [AW:0] cnt_q; // Words held.
  logic doWr; // Word accepted this cycle.
  logic doRd; // Word taken this cycle.

  // Full and empty come straight from the count.
  assign inReady = (cnt_q != (AW+1)'(D));
  assign outValid = (cnt_q != '0);
  assign outData = mem[rdPtr_q];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  // ----------------------------------------------------------
  // Storage; no reset, contents are only read when counted.
  // ----------------------------------------------------------
  always_ff @(posedge clock) begin
    if (doWr) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // ----------------------------------------------------------
  // Pointers and count.
  // ----------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (doWr) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (doWr && !doRd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (doRd && !doWr) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // mlt_fifo

// File: verilog/mlt_top.sv
// Notes on behaviour
// - Receive loop samples sixteen times per bit.
// - Loop free-runs idle, locks on second close edge.
// - Early, centre, late windows steer next cell.
// - Bit valid only if quarter samples differ.
// - Activity on edge; acquire after two edges.
// - Activity output low while line is busy.
// - Activity output held high while transmitting.
// - Mode low inserts and strips own preamble.
// - Async reset inhibits outputs except transmit clock.
// - Clear-to-send rises shortly before data goes out.
// - Both bit clocks derive from reference clock.
// - Manchester coding keeps transitions on line.
`include "mlt_consts.svh"

module mlt_top
  import mlt_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  clock,
  rst_n,
  lineRx,
  lineTx,
  lineDriveN,
  txData,
  rtsN,
  modeSel,
  transmit_bit_clock,
  receive_bit_clock,
  rxData,
  clearToSend,
  carrierSense,
  line_activity_n
);

  input wire logic clock; // Reference clock, sixteen per bit.
  input wire logic rst_n; // Master reset, asynchronous.
  input wire logic lineRx; // Sliced line level.
  output logic lineTx; // Coded line level.
  output logic lineDriveN; // Low while the line is driven.
  input wire logic txData; // Data from the controller.
  input wire logic rtsN; // Request to send, gated outside.
  input wire logic modeSel; // Low selects own preamble.
  output logic transmit_bit_clock; // Bit clock to controller.
  output logic receive_bit_clock; // Recovered bit clock.
  output logic rxData; // Decoded data to controller.
  output logic clearToSend; // Ready for controller data.
  output logic carrierSense; // Receiver delivering data.
  output logic line_activity_n; // Low on foreign activity.

  // ----------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------
  localparam mltState_s ST_RST = '{txState: TX_IDLE, gap: `MLT_GAP_MAX,
    driveN: 1'b1, actN: 1'b1, default: '0};

  mltState_s st_q; // Registered state.
  mltState_s st_d; // Next state.
  mltPins_s pinsRaw; // Pins before synchronising.
  mltPins_s pins; // Pins after synchronising.
  logic [3:0] txDiv_q = 4'h0; // Transmit phase, runs in reset.
  logic txClk_q = 1'b0; // Transmit bit clock flop.
  logic [3:0] txDivN; // Next transmit phase.
  logic boundary; // Last phase of a transmit cell.
  logic rxEdge; // Agreed change on the line input.
  logic bitVal; // Decoded value of the current cell.
  logic fifoInReady; // Buffer can take a bit.
  logic fifoPush; // Controller bit captured.
  logic fifoOutValid; // Buffer holds a bit.
  logic fifoOutData; // Oldest buffered bit.
  logic fifoPop; // Encoder takes a bit.

  assign pinsRaw = '{lineRx: lineRx, txData: txData, rtsN: rtsN,
    modeSel: modeSel};

  // ----------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------
  mlt_sync #(
    .W($bits(mltPins_s)),
    .INIT(`MLT_PIN_INIT)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din(pinsRaw),
    .dout(pins)
  );

  // ----------------------------------------------------------
  // Transmit buffer. It fills while the preamble goes out, and
  // when full it drops clear-to-send to stall the controller.
  // ----------------------------------------------------------
  mlt_fifo #(
    .W(1),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .inData(pins.txData),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoPop)
  );

  assign txDivN = txDiv_q + 4'h1;
  assign boundary = (txDiv_q == `MLT_PH_LAST);
  assign rxEdge = (pins.lineRx != st_q.rxPrev);
  // Capture a quarter into the cell, well after the controller's launch edge.
  assign fifoPush = st_q.cts && !pins.rtsN && (txDiv_q == `MLT_PH_TXSAMP);
  // The encoder drains one bit per cell while sending data.
  assign fifoPop = boundary && fifoOutValid && (st_q.txState != TX_IDLE)
    && (st_q.txState != TX_PRE || st_q.txCnt == `MLT_PRE_LEN);

  // ----------------------------------------------------------
  // Transmit clock divider. It has no reset on purpose so that
  // the transmit clock keeps running through a master reset.
  // ----------------------------------------------------------
  always_ff @(posedge clock) begin
    txDiv_q <= txDivN;
    txClk_q <= ~txDivN[3];
  end

  // ----------------------------------------------------------
  // Next-state logic for transmitter and receiver.
  // ----------------------------------------------------------
  always_comb begin
    st_d = st_q;
    bitVal = st_q.s4;

    // Transmit sequencer advances on cell boundaries only.
    if (boundary) begin
      case (st_q.txState)
        TX_IDLE: begin
          if (!pins.rtsN) begin
            st_d.txCnt = 4'h0;
            // Mode low sends the block's own preamble first.
            st_d.txState = pins.modeSel ? TX_DATA : TX_PRE;
          end
        end
        TX_PRE: begin
          if (st_q.txCnt == `MLT_PRE_LEN) begin
            st_d.txState = TX_DATA;
          end
        end
        TX_DATA: begin
          st_d.txState = TX_DATA;
        end
        default: begin
          st_d.txState = TX_IDLE;
        end
      endcase
      if (st_d.txState == TX_PRE) begin
        // Preamble goes out most significant bit first.
        st_d.txBit = 1'(`MLT_PRE_BITS >> (3'h7 - st_d.txCnt[2:0]));
        st_d.txCnt = st_d.txCnt + 4'h1;
      end else if (st_d.txState == TX_DATA) begin
        if (fifoOutValid) begin
          st_d.txBit = fifoOutData;
        end else if (pins.rtsN) begin
          st_d.txState = TX_IDLE;
        end else begin
          // Underrun or early start: idle ones keep edges alive.
          st_d.txBit = 1'b1;
        end
      end
    end

    // Clear-to-send leads the data by three preamble cells and
    // drops on back-pressure; request is already gated outside.
    st_d.cts = (st_d.txState == TX_DATA || (st_d.txState == TX_PRE
      && st_d.txCnt >= `MLT_CTS_AT)) && !pins.rtsN && fifoInReady;
    st_d.driveN = (st_d.txState == TX_IDLE);
    // First half carries the bit, second half its inverse.
    st_d.lineOut = !st_d.driveN && (st_d.txBit ^ txDivN[3]);

    // Activity detector and transition spacing.
    st_d.rxPrev = pins.lineRx;
    if (rxEdge) begin
      st_d.quiet = 6'h00;
      st_d.gap = 5'h00;
      st_d.active = 1'b1;
      if (st_q.gap < `MLT_ACQ_WIN) begin
        st_d.acq = 1'b1;
      end
    end else begin
      if (st_q.gap != `MLT_GAP_MAX) begin
        st_d.gap = st_q.gap + 5'h01;
      end
      if (st_q.quiet == `MLT_QUIET_LAST) begin
        // Two quiet cells end activity and drop the lock.
        st_d.active = 1'b0;
        st_d.acq = 1'b0;
        st_d.locked = 1'b0;
      end else begin
        st_d.quiet = st_q.quiet + 6'h01;
      end
    end

    // Recovery loop phase; free-runs whenever unlocked.
    st_d.rxPh = st_q.rxPh + 4'h1;
    if (st_q.rxPh == `MLT_PH_LAST) begin
      // Corrections apply only while locked, so an unlocked loop free-runs.
      if (st_q.locked && st_q.shorten) begin
        st_d.rxPh = `MLT_PH_SHORT;
      end else if (st_q.locked && st_q.lengthen) begin
        st_d.rxPh = `MLT_PH_LAST;
      end
      st_d.shorten = 1'b0;
      st_d.lengthen = 1'b0;
    end

    // Window flags; a centre hit clears both corrections.
    if (st_q.locked && rxEdge) begin
      if (st_q.rxPh >= `MLT_WIN_E_LO && st_q.rxPh <= `MLT_WIN_E_HI) begin
        st_d.shorten = 1'b1;
        st_d.lengthen = 1'b0;
      end else if (st_q.rxPh == `MLT_PH_MID) begin
        st_d.shorten = 1'b0;
        st_d.lengthen = 1'b0;
      end else if (st_q.rxPh >= `MLT_WIN_L_LO && st_q.rxPh <= `MLT_WIN_L_HI) begin
        st_d.lengthen = 1'b1;
        st_d.shorten = 1'b0;
      end
    end

    // First qualified edge is taken as mid-cell.
    if (!st_q.locked && rxEdge && (st_q.acq || st_q.gap < `MLT_ACQ_WIN)) begin
      st_d.locked = 1'b1;
      st_d.rxPh = `MLT_PH_RELOCK;
      st_d.shorten = 1'b0;
      st_d.lengthen = 1'b0;
      st_d.hunt = !pins.modeSel;
      st_d.lastOne = 1'b0;
      // The locking edge is mid-cell, so the first half held the inverse.
      st_d.s4 = !pins.lineRx;
    end

    // Quarter-point samples decide the bit.
    if (st_q.locked && st_q.rxPh == `MLT_PH_Q1) begin
      st_d.s4 = pins.lineRx;
    end
    if (st_q.locked && st_q.rxPh == `MLT_PH_Q3) begin
      if (pins.lineRx == st_q.s4) begin
        // No mid-cell change: not a coded bit, search again.
        st_d.locked = 1'b0;
      end else if (st_q.hunt) begin
        // Preamble ends with two ones; both are swallowed.
        if (bitVal && st_q.lastOne) begin
          st_d.hunt = 1'b0;
        end
        st_d.lastOne = bitVal;
      end else begin
        st_d.pend = bitVal;
        st_d.pendV = 1'b1;
      end
    end

    // Data is launched on the rising receive clock edge.
    if (st_q.rxPh == `MLT_PH_LAST && st_q.pendV) begin
      st_d.rxData = st_q.pend;
      st_d.pendV = 1'b0;
    end
    // Carrier rises with the first delivered bit, so no receive clock
    // fall ever hands the controller a stale bit after stripping.
    st_d.carrier = st_d.locked && !st_d.hunt
      && (st_q.carrier || (st_q.rxPh == `MLT_PH_LAST && st_q.pendV));
    st_d.rxClk = st_d.carrier && !st_d.rxPh[3];

    // Own transmission is masked only while the transmit sequencer is not idle; its echo still shows until the line goes quiet.
    st_d.actN = !(st_q.active && st_q.txState == TX_IDLE);
  end

  // ----------------------------------------------------------
  // State register; reset parks every output but the transmit clock inactive.
  // ----------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign lineTx = st_q.lineOut;
  assign lineDriveN = st_q.driveN;
  assign transmit_bit_clock = txClk_q;
  assign receive_bit_clock = st_q.rxClk;
  assign rxData = st_q.rxData;
  assign clearToSend = st_q.cts;
  assign carrierSense = st_q.carrier;
  assign line_activity_n = st_q.actN;

  // ----------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence sPreStart;
    st_q.txState == TX_IDLE ##1 st_q.txState == TX_PRE;
  endsequence

  a_free_run:
    assert property ((!st_q.locked && !st_d.locked)
      |-> st_d.rxPh == st_q.rxPh + 4'h1)
    else $error("Unlocked loop did not step by one.");

  a_lock_phase:
    assert property ((!st_q.locked && st_d.locked) |=> st_q.rxPh == 4'h9)
    else $error("Lock did not place edge at mid-cell.");

  a_early_flag:
    assert property ((st_q.locked && rxEdge && st_q.rxPh >= 4'h5
      && st_q.rxPh <= 4'h7) |=> st_q.shorten)
    else $error("Early edge did not set shorten.");

  a_bit_check:
    assert property ((st_q.locked && st_q.rxPh == 4'hc
      && pins.lineRx == st_q.s4) |=> !st_q.locked)
    else $error("Cell without mid change kept lock.");

  a_acq_cause:
    assert property ($rose(st_q.acq) |-> $past(rxEdge) && $past(st_q.gap) < 5'h10)
    else $error("Acquired without two close edges.");

  a_act_shown:
    assert property ((st_q.active && st_q.txState == TX_IDLE) |=> !line_activity_n)
    else $error("Activity not signalled.");

  a_tx_mask:
    assert property (st_q.txState != TX_IDLE |=> line_activity_n)
    else $error("Activity shown during own transmission.");

  a_mode_pre:
    assert property (sPreStart |-> !$past(pins.modeSel))
    else $error("Preamble sent in mode one.");

  a_cts_lead:
    assert property ($rose(clearToSend) |-> st_q.txState != TX_IDLE && !lineDriveN)
    else $error("Clear-to-send while not transmitting.");

  a_mid_change:
    assert property ((!st_q.driveN && !$past(st_q.driveN) && txDiv_q == 4'h8)
      |-> st_q.lineOut != $past(st_q.lineOut) && st_q.lineOut == !st_q.txBit)
    else $error("Missing or wrong mid-cell transition.");

endmodule // mlt_top

// File: sim/mlt_ctrl_model.sv
// ----------------------------------------------------------
// Serial controller seen from the transceiver's far side.
// ----------------------------------------------------------
module mlt_ctrl_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic transmit_bit_clock,
  input wire logic receive_bit_clock,
  input wire logic rxData,
  input wire logic clearToSend,
  input wire logic line_activity_n,
  output logic txData,
  output logic rtsN
);
  timeunit 1ns;
  timeprecision 100ps;

  logic txQ[$]; // Bits waiting to be sent, oldest first.
  logic rxQ[$]; // Bits captured from the receive side.
  logic txClkQ; // Last seen level of the transmit bit clock.
  logic reqN; // Raw request, before the activity gate.

  // The controller launches a bit on the falling transmit clock. The request
  // is released one cell after the last bit, so that bit is still taken.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txData <= 1'b1;
      reqN <= 1'b1;
      rtsN <= 1'b1;
      txClkQ <= 1'b0;
    end else begin
      txClkQ <= transmit_bit_clock;
      if (txClkQ && !transmit_bit_clock) begin
        reqN <= (txQ.size() == 0);
        if (clearToSend && txQ.size() > 0) begin
          txData <= txQ.pop_front();
        end else begin
          txData <= 1'b1; // Idle marks while nothing is queued.
        end
      end
      rtsN <= reqN | ~line_activity_n;
    end
  end

  // Data is taken on the inverted receive clock, opposite to its launch edge.
  always @(negedge receive_bit_clock) begin
    if (rst_n) begin
      rxQ.push_back(rxData);
    end
  end
endmodule // mlt_ctrl_model

// File: sim/tb_top.sv
`include "mlt_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------
  // Signals.
  // ----------------------------------------------------------
  logic clock, rst_n, modeSel, txData, rtsN;
  logic lineGen; // Level driven by a foreign station.
  logic loopSel; // High folds our own line output back in.
  logic linkClk; // Half-cell clock of the foreign station.
  logic lineRx, lineTx, lineDriveN, transmit_bit_clock, receive_bit_clock;
  logic rxData, clearToSend, carrierSense, line_activity_n;
  int err_count, cmp_count;

  assign lineRx = loopSel ? lineTx : lineGen;

  mlt_top #(.FIFO_DEPTH(16)) dut_u (
    .clock(clock), .rst_n(rst_n), .lineRx(lineRx), .lineTx(lineTx), .lineDriveN(lineDriveN),
    .txData(txData), .rtsN(rtsN), .modeSel(modeSel), .transmit_bit_clock(transmit_bit_clock),
    .receive_bit_clock(receive_bit_clock), .rxData(rxData), .clearToSend(clearToSend),
    .carrierSense(carrierSense), .line_activity_n(line_activity_n)
  );

  mlt_ctrl_model ctrlU (
    .clock(clock), .rst_n(rst_n), .transmit_bit_clock(transmit_bit_clock),
    .receive_bit_clock(receive_bit_clock), .rxData(rxData), .clearToSend(clearToSend),
    .line_activity_n(line_activity_n), .txData(txData), .rtsN(rtsN)
  );

  // ----------------------------------------------------------
  // Shared helpers.
  // ----------------------------------------------------------
  // Reference clock at 40 MHz.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Counts one comparison and reports a difference at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  // Waits, bounded, for the line driver to reach a level.
  task automatic wait_drive(input logic lvl);
    for (int k = 0; k < 400 && lineDriveN !== lvl; k++) @(negedge clock);
    chk(lineDriveN, lvl);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------
  // A lone edge marks activity but must not acquire the clock.
  task automatic noise_edge();
    logic cs;
    cs = 1'b0;
    @(posedge clock);
    loopSel <= 1'b0;
    #3 lineGen = 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge clock);
      if (carrierSense === 1'b1) cs = 1'b1;
      if (k == 8) chk(line_activity_n, 1'b0);
    end
    chk(cs, 1'b0);
    lineGen = 1'b0;
    repeat (40) @(negedge clock);
    chk(line_activity_n, 1'b1);
  endtask

  // Sends one byte through the controller and decodes the line cell by cell.
  // The line is looped back, so the receiver sees traffic during our frame.
  task automatic tx_frame(input logic md, input logic [7:0] dat);
    logic cells[$];
    logic a, b;
    int n, i, ctsCell;
    ctsCell = -1;
    @(posedge clock);
    modeSel <= md;
    loopSel <= 1'b1;
    for (i = 7; i >= 0; i--) ctrlU.txQ.push_back(dat[i]);
    wait_drive(1'b0);
    repeat (3) @(negedge clock);
    for (n = 0; n < 40 && lineDriveN === 1'b0; n++) begin
      a = lineTx;
      if (clearToSend === 1'b1 && ctsCell < 0) ctsCell = n;
      chk(line_activity_n, 1'b1);
      repeat (8) @(negedge clock);
      b = lineTx;
      chk(b, !a);
      cells.push_back(a);
      repeat (8) @(negedge clock);
    end
    i = 0;
    if (md == 1'b0) begin
      for (i = 0; i < 8; i++) chk(cells[i], `MLT_PRE_BITS >> (7 - i) & 8'h01);
    end
    // An empty buffer sends ones, so skip them up to the leading zero.
    while (i < cells.size() && cells[i] === 1'b1) i++;
    for (n = 7; n >= 0; n--) begin
      chk(cells[i], dat[n]);
      i++;
    end
    chk((ctsCell >= 0) && (md || ctsCell > 0), 1'b1);
  endtask

  // A foreign station sends preamble and byte; half-cell time sets drift.
  task automatic rx_frame(input logic md, input int halfNs, input logic [7:0] dat);
    logic [15:0] s;
    logic [7:0] w;
    int idx;
    s = {`MLT_PRE_BITS, dat};
    idx = -1;
    @(posedge clock);
    modeSel <= md;
    loopSel <= 1'b0;
    repeat (40) @(posedge clock);
    ctrlU.rxQ.delete();
    #3;
    for (int i = 15; i >= 0; i--) begin
      for (int h = 0; h < 2; h++) begin
        linkClk = 1'b1;
        lineGen = s[i] ^ h[0];
        #(halfNs / 2);
        linkClk = 1'b0;
        #(halfNs / 2);
      end
      if (i == 3) begin
        chk(line_activity_n, 1'b0);
        chk(carrierSense, 1'b1);
      end
    end
    lineGen = 1'b0;
    repeat (40) @(negedge clock);
    chk({line_activity_n, carrierSense}, 8'h02);
    for (int i = 0; i + 8 <= ctrlU.rxQ.size(); i++) begin
      w = 8'h00;
      for (int j = 0; j < 8; j++) w = {w[6:0], ctrlU.rxQ[i + j]};
      if (w === dat && idx < 0) idx = i;
    end
    chk(idx >= 0, 1'b1);
    if (md == 1'b0) chk(idx == 0, 1'b1);
  endtask

  // Reset in mid-frame: outputs drop at once while the bit clock runs on.
  task automatic tx_abort();
    int toggles;
    logic prev;
    @(posedge clock);
    modeSel <= 1'b0;
    loopSel <= 1'b1;
    for (int i = 0; i < 8; i++) ctrlU.txQ.push_back(1'b0);
    wait_drive(1'b0);
    repeat (20) @(posedge clock);
    rst_n <= 1'b0;
    #2;
    chk({lineTx, lineDriveN, clearToSend, carrierSense, receive_bit_clock, rxData, line_activity_n}, 8'h21);
    toggles = 0;
    prev = transmit_bit_clock;
    for (int k = 0; k < 32; k++) begin
      @(negedge clock);
      if (transmit_bit_clock !== prev) toggles++;
      prev = transmit_bit_clock;
    end
    chk(toggles, 4);
    ctrlU.txQ.delete();
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask

  // ----------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    modeSel = 1'b0;
    lineGen = 1'b0;
    loopSel = 1'b0;
    linkClk = 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    noise_edge();
    tx_frame(1'b0, 8'h5a);
    tx_frame(1'b1, 8'h5a);
    tx_frame(1'b0, 8'h7f);
    tx_frame(1'b0, 8'h00);
    rx_frame(1'b0, 200, 8'h5a);
    rx_frame(1'b1, 200, 8'h96);
    rx_frame(1'b0, 190, 8'h3c);
    rx_frame(1'b0, 210, 8'h3c);
    tx_abort();
    tx_frame(1'b0, 8'h5a);
    stop_test();
  end

  // The sequence needs about 3000 cycles; this limit leaves ample margin.
  initial begin
    #2000000;
    $display("watchdog expired at %0t", $time);
    err_count++;
    stop_test();
  end
endmodule // tb_top
